// [src/esc_counter.sv]
`timescale 1ns/1ps
// ==========================================
// one wrapping counter with clear
module esc_counter #(
    parameter int W = 32,
    parameter int INC_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic [INC_W-1:0] inc,
    // value
    output logic [W-1:0] value
);
    import esc_pkg::*;

    logic [W-1:0] value_reg; // stored count
    logic [W-1:0] value_next; // next count

    // next value: clear beats any increment
    always_comb begin
        if (clear) begin
            value_next = W'(CNT_RST);
        end else begin
            // modulo add, keeps the low W bits when it wraps
            value_next = value_reg + W'(inc);
        end
    end

    // register only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_reg <= '0;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule : esc_counter

// [src/esc_pkg.sv]
// ==========================================
// port statistics: shared constants and types
package esc_pkg;

    // ==========================================
    // widths
    localparam int CNT_W = 32; // counter width
    localparam int LEN_W = 16; // frame length field
    localparam int COLL_W = 5; // attempt collision count
    localparam int NUM_CNT = 23; // counters in the bank

    // ==========================================
    // reset and clear value of every counter
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

    // ==========================================
    // counter positions in the bank
    localparam int IDX_OCT_IN = 0; // octets received
    localparam int IDX_OCT_OUT = 1; // octets sent
    localparam int IDX_UNI_IN = 2; // unicast received
    localparam int IDX_UNI_OUT = 3; // unicast sent
    localparam int IDX_GRP_IN = 4; // non-unicast received
    localparam int IDX_GRP_OUT = 5; // non-unicast sent
    localparam int IDX_DISC_IN = 6; // dropped inbound
    localparam int IDX_DISC_OUT = 7; // dropped outbound
    localparam int IDX_ERR_IN = 8; // errored inbound
    localparam int IDX_ERR_OUT = 9; // errored outbound
    localparam int IDX_UNK_PROTO = 10; // unknown protocol
    localparam int IDX_ALIGN = 11; // alignment errors
    localparam int IDX_FCS = 12; // checksum errors
    localparam int IDX_COLL_ONE = 13; // single collision
    localparam int IDX_COLL_MULTI = 14; // multiple collisions
    localparam int IDX_SQE = 15; // signal quality test errors
    localparam int IDX_DEFER = 16; // deferred sends
    localparam int IDX_LATE = 17; // late collisions
    localparam int IDX_EXCESS = 18; // excessive collisions
    localparam int IDX_MAC_TX = 19; // internal send errors
    localparam int IDX_MAC_RX = 20; // internal receive errors
    localparam int IDX_CARRIER = 21; // carrier sense lost
    localparam int IDX_TOO_LONG = 22; // oversize frames

    // ==========================================
    // one received frame, pulsed at frame end
    typedef struct packed {
        logic valid; // frame finished this cycle
        logic [LEN_W-1:0] len; // length in octets
        logic unicast; // individual address
        logic group; // multicast or broadcast
        logic discard; // dropped, not delivered
        logic error; // errored frame
        logic unk_proto; // protocol not recognised
        logic align_err; // not whole octets
        logic fcs_err; // check sequence failed
        logic mac_err; // internal receive error
        logic too_long; // above largest size
    } esc_rx_evt_t;

    // ==========================================
    // one sent frame, pulsed at attempt end
    typedef struct packed {
        logic valid; // frame finished this cycle
        logic [LEN_W-1:0] len; // length in octets
        logic unicast; // individual address
        logic group; // multicast or broadcast
        logic discard; // dropped, not sent
        logic error; // errored frame
        logic sent_ok; // went out successfully
        logic [COLL_W-1:0] coll; // collisions met
        logic deferred; // first attempt waited
        logic excessive; // abandoned, too many coll
        logic mac_err; // internal send error
        logic carrier_lost; // carrier dropped/absent
    } esc_tx_evt_t;

    // ==========================================
    // the whole counter bank
    typedef logic [NUM_CNT-1:0][CNT_W-1:0] esc_bank_t;

endpackage : esc_pkg

// [src/esc_stats.sv]
`timescale 1ns/1ps
// How it works
// - add accepted receive frame octets
// - add sent frame octets
// - count unicast packets per direction
// - count multicast/broadcast packets per direction
// - count dropped packets per direction
// - count errored packets, excluding dropped ones
// - count received unknown-protocol packets
// - count received non-whole-octet frames
// - count received checksum failures
// - count successes after exactly one collision
// - count successes after several collisions
// - count signal quality test errors
// - count frames deferred on first attempt
// - count collisions past 512 bit-times
// - count frames abandoned for excess collisions
// - count internal send failures
// - count internal receive failures
// - count carrier lost or absent
// - count received oversize frames
// - clear zeroes every counter together
module esc_stats (
    // ==========================================
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // management command
    input wire logic CLEAR,
    // receive path frame report
    input wire esc_pkg::esc_rx_evt_t RX_EVT,
    // transmit path frame report
    input wire esc_pkg::esc_tx_evt_t TX_EVT,
    // transmit path instant pulses
    input wire logic LATE_COLL,
    input wire logic SQE_ERR,
    // counter bank, registered
    output esc_pkg::esc_bank_t COUNTS
);
    import esc_pkg::*;

    // ==========================================
    // frame qualifiers
    logic rx_v; // a receive report this cycle
    logic tx_v; // a transmit report this cycle
    logic rx_acc; // received and delivered
    logic tx_acc; // sent and not dropped
    logic tx_one; // success after one collision
    logic tx_multi; // success after several

    // per-counter increment amounts
    logic [NUM_CNT-1:0][LEN_W-1:0] inc;

    // one-bit event widened to an increment
    function automatic logic [LEN_W-1:0] one(
        input logic ev
    );
        one = {{(LEN_W-1){1'b0}}, ev};
    endfunction : one

    // length added only when the frame counts
    function automatic logic [LEN_W-1:0] octs(
        input logic ev,
        input logic [LEN_W-1:0] len
    );
        octs = ev ? len : '0;
    endfunction : octs

    // ==========================================
    // qualify the reports
    always_comb begin
        rx_v = RX_EVT.valid;
        tx_v = TX_EVT.valid;
        // delivered: neither dropped nor errored; sent: sent_ok and not dropped
        rx_acc = rx_v && !RX_EVT.discard && !RX_EVT.error;
        tx_acc = tx_v && TX_EVT.sent_ok && !TX_EVT.discard;
        // collision history of a good frame
        tx_one = tx_acc && (TX_EVT.coll == COLL_W'(1));
        tx_multi = tx_acc && (TX_EVT.coll > COLL_W'(1));
    end

    // ==========================================
    // map events onto the counter bank
    always_comb begin
        inc = '0;
        // octet totals
        inc[IDX_OCT_IN] = octs(rx_acc, RX_EVT.len);
        inc[IDX_OCT_OUT] = octs(tx_acc, TX_EVT.len);
        // address class counts
        inc[IDX_UNI_IN] = one(rx_acc && RX_EVT.unicast);
        inc[IDX_UNI_OUT] = one(tx_acc && TX_EVT.unicast);
        inc[IDX_GRP_IN] = one(rx_acc && RX_EVT.group);
        inc[IDX_GRP_OUT] = one(tx_acc && TX_EVT.group);
        // dropped frames
        inc[IDX_DISC_IN] = one(rx_v && RX_EVT.discard);
        inc[IDX_DISC_OUT] = one(tx_v && TX_EVT.discard);
        // errored frames not already dropped
        inc[IDX_ERR_IN] =
            one(rx_v && RX_EVT.error && !RX_EVT.discard);
        inc[IDX_ERR_OUT] =
            one(tx_v && TX_EVT.error && !TX_EVT.discard);
        // protocol not recognised
        inc[IDX_UNK_PROTO] = one(rx_v && RX_EVT.unk_proto);
        // receive media errors
        inc[IDX_ALIGN] = one(rx_v && RX_EVT.align_err);
        inc[IDX_FCS] = one(rx_v && RX_EVT.fcs_err);
        inc[IDX_MAC_RX] = one(rx_v && RX_EVT.mac_err);
        inc[IDX_TOO_LONG] = one(rx_v && RX_EVT.too_long);
        // collision history of good frames
        inc[IDX_COLL_ONE] = one(tx_one);
        inc[IDX_COLL_MULTI] = one(tx_multi);
        // instant pulses, independent of frame end
        inc[IDX_SQE] = one(SQE_ERR);
        inc[IDX_LATE] = one(LATE_COLL);
        // transmit media errors
        inc[IDX_DEFER] = one(tx_v && TX_EVT.deferred);
        inc[IDX_EXCESS] = one(tx_v && TX_EVT.excessive);
        inc[IDX_MAC_TX] = one(tx_v && TX_EVT.mac_err);
        inc[IDX_CARRIER] =
            one(tx_v && TX_EVT.carrier_lost);
    end

    // ==========================================
    // the counter bank; each has its own adder
    // so events in one cycle never compete
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            esc_counter #(
                .W(CNT_W),
                .INC_W(LEN_W)
            ) u_cnt (
                .clk(CLOCK),
                .rst(SYS_RST),
                .clear(CLEAR),
                .inc(inc[gi]),
                .value(COUNTS[gi])
            );
        end
    endgenerate

    // ==========================================
    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    // clear then a delivered unicast frame
    sequence s_clear_then_uni;
        CLEAR ##1 (rx_acc && RX_EVT.unicast && !CLEAR);
    endsequence

    // a good frame with exactly one collision
    sequence s_tx_one;
        tx_v && TX_EVT.sent_ok && !TX_EVT.discard
            && TX_EVT.coll == COLL_W'(1) && !CLEAR;
    endsequence

    chk_rx_octets_add: assert property (
        (rx_acc && !CLEAR) |=> COUNTS[IDX_OCT_IN] ==
            $past(COUNTS[IDX_OCT_IN]) + CNT_W'($past(RX_EVT.len)))
        else $error("inbound octets not added");

    chk_tx_octets_add: assert property (
        (tx_acc && !CLEAR) |=> COUNTS[IDX_OCT_OUT] ==
            $past(COUNTS[IDX_OCT_OUT]) + CNT_W'($past(TX_EVT.len)))
        else $error("outbound octets not added");

    chk_uni_after_clear: assert property (
        s_clear_then_uni |=> COUNTS[IDX_UNI_IN] == 32'h0000_0001)
        else $error("unicast count wrong after clear");

    chk_grp_tx_step: assert property (
        (tx_acc && TX_EVT.group && !CLEAR) |=>
            COUNTS[IDX_GRP_OUT] == $past(COUNTS[IDX_GRP_OUT]) + 1)
        else $error("non-unicast send not counted");

    chk_disc_not_err: assert property (
        (rx_v && RX_EVT.discard && !CLEAR) |=>
            $stable(COUNTS[IDX_ERR_IN])
            && COUNTS[IDX_DISC_IN] != $past(COUNTS[IDX_DISC_IN]))
        else $error("dropped frame counted as errored");

    chk_one_coll: assert property (
        s_tx_one |=> COUNTS[IDX_COLL_ONE] ==
            $past(COUNTS[IDX_COLL_ONE]) + 1
            && $stable(COUNTS[IDX_COLL_MULTI]))
        else $error("single collision miscounted");

    chk_late_pulse: assert property (
        (LATE_COLL && !CLEAR) |=> COUNTS[IDX_LATE] ==
            $past(COUNTS[IDX_LATE]) + 1)
        else $error("late collision not counted");

    chk_sqe_pulse: assert property (
        (SQE_ERR && !CLEAR) |=> COUNTS[IDX_SQE] ==
            $past(COUNTS[IDX_SQE]) + 1)
        else $error("quality test error not counted");

    chk_fcs_rx: assert property (
        (rx_v && RX_EVT.fcs_err && !CLEAR) |=> COUNTS[IDX_FCS] ==
            $past(COUNTS[IDX_FCS]) + 1)
        else $error("checksum error not counted");

    chk_clear_all: assert property (
        CLEAR |=> COUNTS == '0)
        else $error("clear left a counter nonzero");

    chk_clear_wins: assert property (
        (CLEAR && (rx_v || tx_v || LATE_COLL)) |=> COUNTS == '0)
        else $error("increment beat clear");

    chk_idle_hold: assert property (
        (!rx_v && !tx_v && !LATE_COLL && !SQE_ERR && !CLEAR)
            |=> $stable(COUNTS))
        else $error("counter moved with no event");

    // ==========================================
    // per-counter steps for the remaining events

    // a good frame with more than one collision
    sequence s_tx_multi;
        tx_v && TX_EVT.sent_ok && !TX_EVT.discard
            && TX_EVT.coll > COLL_W'(1) && !CLEAR;
    endsequence

    // delivered unicast frame adds one
    chk_uni_rx_step: assert property (
        (rx_acc && RX_EVT.unicast && !CLEAR) |=>
            COUNTS[IDX_UNI_IN] == $past(COUNTS[IDX_UNI_IN]) + 32'h1)
        else $error("unicast receive not counted");

    // delivered group frame adds one
    chk_grp_rx_step: assert property (
        (rx_acc && RX_EVT.group && !CLEAR) |=>
            COUNTS[IDX_GRP_IN] == $past(COUNTS[IDX_GRP_IN]) + 32'h1)
        else $error("non-unicast receive not counted");

    // dropped send counts once, never as errored
    chk_disc_tx_step: assert property (
        (tx_v && TX_EVT.discard && !CLEAR) |=>
            $stable(COUNTS[IDX_ERR_OUT])
            && COUNTS[IDX_DISC_OUT] == $past(COUNTS[IDX_DISC_OUT]) + 32'h1)
        else $error("dropped send miscounted");

    // errored receive that was not dropped
    chk_err_rx_step: assert property (
        (rx_v && RX_EVT.error && !RX_EVT.discard && !CLEAR) |=>
            COUNTS[IDX_ERR_IN] == $past(COUNTS[IDX_ERR_IN]) + 32'h1)
        else $error("errored receive not counted");

    // unknown protocol on receive
    chk_unk_proto: assert property (
        (rx_v && RX_EVT.unk_proto && !CLEAR) |=> COUNTS[IDX_UNK_PROTO] ==
            $past(COUNTS[IDX_UNK_PROTO]) + 32'h1)
        else $error("unknown protocol not counted");

    // frame not a whole number of octets
    chk_align_rx: assert property (
        (rx_v && RX_EVT.align_err && !CLEAR) |=> COUNTS[IDX_ALIGN] ==
            $past(COUNTS[IDX_ALIGN]) + 32'h1)
        else $error("alignment error not counted");

    // several collisions, single counter untouched
    chk_multi_coll: assert property (
        s_tx_multi |=> COUNTS[IDX_COLL_MULTI] ==
            $past(COUNTS[IDX_COLL_MULTI]) + 32'h1
            && $stable(COUNTS[IDX_COLL_ONE]))
        else $error("multiple collisions miscounted");

    // first attempt had to wait
    chk_defer_tx: assert property (
        (tx_v && TX_EVT.deferred && !CLEAR) |=> COUNTS[IDX_DEFER] ==
            $past(COUNTS[IDX_DEFER]) + 32'h1)
        else $error("deferred send not counted");

    // abandoned after too many collisions
    chk_excess_tx: assert property (
        (tx_v && TX_EVT.excessive && !CLEAR) |=> COUNTS[IDX_EXCESS] ==
            $past(COUNTS[IDX_EXCESS]) + 32'h1)
        else $error("excessive collisions not counted");

    // internal send failure
    chk_mac_tx: assert property (
        (tx_v && TX_EVT.mac_err && !CLEAR) |=> COUNTS[IDX_MAC_TX] ==
            $past(COUNTS[IDX_MAC_TX]) + 32'h1)
        else $error("internal send error not counted");

    // internal receive failure
    chk_mac_rx: assert property (
        (rx_v && RX_EVT.mac_err && !CLEAR) |=> COUNTS[IDX_MAC_RX] ==
            $past(COUNTS[IDX_MAC_RX]) + 32'h1)
        else $error("internal receive error not counted");

    // carrier lost or never seen while sending
    chk_carrier_tx: assert property (
        (tx_v && TX_EVT.carrier_lost && !CLEAR) |=> COUNTS[IDX_CARRIER] ==
            $past(COUNTS[IDX_CARRIER]) + 32'h1)
        else $error("carrier loss not counted");

    // received frame above the largest size
    chk_too_long: assert property (
        (rx_v && RX_EVT.too_long && !CLEAR) |=> COUNTS[IDX_TOO_LONG] ==
            $past(COUNTS[IDX_TOO_LONG]) + 32'h1)
        else $error("oversize frame not counted");

endmodule : esc_stats

// [verif/esc_mac_model.sv]
`timescale 1ns/1ps
// ==========================================
// behavioural mac paths: frame reports and pulses
module esc_mac_model (
    // clock
    input wire logic clk,
    // frame reports toward the counters
    output esc_pkg::esc_rx_evt_t rx_evt,
    output esc_pkg::esc_tx_evt_t tx_evt,
    // instant pulses
    output logic late_coll,
    output logic sqe_err
);
    import esc_pkg::*;

    // quiet lines at time zero
    initial begin
        rx_evt = '0;
        tx_evt = '0;
        late_coll = 1'h0;
        sqe_err = 1'h0;
    end

    // one receive report for one cycle, then flipped junk with valid low
    task automatic send_rx(input esc_rx_evt_t ev);
        esc_rx_evt_t junk;
        junk = ~ev;
        junk.valid = 1'h0;
        @(negedge clk);
        rx_evt <= ev;
        @(negedge clk);
        rx_evt <= junk;
    endtask : send_rx

    // one transmit report, same shape as receive
    task automatic send_tx(input esc_tx_evt_t ev);
        esc_tx_evt_t junk;
        junk = ~ev;
        junk.valid = 1'h0;
        @(negedge clk);
        tx_evt <= ev;
        @(negedge clk);
        tx_evt <= junk;
    endtask : send_tx

    // late collision and quality test error flags come from the caller, pulsed one cycle
    task automatic pulse(input logic late, input logic sqe);
        @(negedge clk);
        late_coll <= late;
        sqe_err <= sqe;
        @(negedge clk);
        late_coll <= 1'h0;
        sqe_err <= 1'h0;
    endtask : pulse
endmodule : esc_mac_model

// [verif/testbench.sv]
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the statistics bank
module testbench;
    import esc_pkg::*;
    logic clk, rst, clear, late_coll, sqe_err; // stimulus
    esc_rx_evt_t rx_evt; // receive report
    esc_tx_evt_t tx_evt; // transmit report
    esc_bank_t counts; // observed bank
    logic [CNT_W-1:0] exp_cnt [NUM_CNT]; // expected bank
    int err_count;
    int check_count;

    // ==========================================
    // clock, partner and design
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    esc_mac_model mac (.clk(clk), .rx_evt(rx_evt), .tx_evt(tx_evt),
        .late_coll(late_coll), .sqe_err(sqe_err));
    esc_stats dut (.CLOCK(clk), .SYS_RST(rst), .CLEAR(clear),
        .RX_EVT(rx_evt), .TX_EVT(tx_evt), .LATE_COLL(late_coll),
        .SQE_ERR(sqe_err), .COUNTS(counts));

    // ==========================================
    // compare whole bank against expectation, then report test end
    task automatic check_bank(input string name);
        for (int i = 0; i < NUM_CNT; i++) begin
            check_count++;
            if (counts[i] !== exp_cnt[i]) begin
                err_count++;
                $display("Error at %0t: %s counter %0d is %0h, want %0h",
                    $time, name, i, counts[i], exp_cnt[i]);
            end
        end
        $display("test %s done", name);
    endtask : check_bank

    // verdict and end of run
    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // ==========================================
    // receive frames: accepted, dropped, errored, flagged
    task automatic t_rx;
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0040, 9'h100}));
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h05DC, 9'h080}));
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0080, 9'h160}));
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0040, 9'h020}));
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0010, 9'h01F}));
        exp_cnt[IDX_OCT_IN] += 32'h0000_062C;
        exp_cnt[IDX_UNI_IN] += 32'h1;
        exp_cnt[IDX_GRP_IN] += 32'h1;
        exp_cnt[IDX_DISC_IN] += 32'h1;
        exp_cnt[IDX_ERR_IN] += 32'h1;
        exp_cnt[IDX_UNK_PROTO] += 32'h1;
        exp_cnt[IDX_ALIGN] += 32'h1;
        exp_cnt[IDX_FCS] += 32'h1;
        exp_cnt[IDX_MAC_RX] += 32'h1;
        exp_cnt[IDX_TOO_LONG] += 32'h1;
        check_bank("rx");
        // flags above
    endtask : t_rx

    // transmit frames: collisions, deferral, failures, drops
    task automatic t_tx;
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0064, 4'h8, 1'h1, 5'h01, 4'h8}));
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0040, 4'h4, 1'h1, 5'h03, 4'h0}));
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'h003C, 4'h8, 1'h1, 5'h00, 4'h0}));
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0050, 4'hB, 1'h1, 5'h01, 4'h0}));
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0050, 4'h1, 1'h0, 5'h10, 4'h7}));
        mac.send_tx(esc_tx_evt_t'({1'h1, 16'hFFFF, 4'h4, 1'h1, 5'h1F, 4'h0}));
        exp_cnt[IDX_OCT_OUT] += 32'h0001_00DF;
        exp_cnt[IDX_UNI_OUT] += 32'h2;
        exp_cnt[IDX_GRP_OUT] += 32'h2;
        exp_cnt[IDX_DISC_OUT] += 32'h1;
        exp_cnt[IDX_ERR_OUT] += 32'h1;
        exp_cnt[IDX_COLL_ONE] += 32'h1;
        exp_cnt[IDX_COLL_MULTI] += 32'h2;
        exp_cnt[IDX_DEFER] += 32'h1;
        exp_cnt[IDX_EXCESS] += 32'h1;
        exp_cnt[IDX_MAC_TX] += 32'h1;
        exp_cnt[IDX_CARRIER] += 32'h1;
        check_bank("tx");
        // outcomes above
    endtask : t_tx

    // pulses coinciding with both frame reports in one cycle
    task automatic t_pulse;
        fork
            mac.pulse(1'h1, 1'h1);
            mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0020, 9'h100}));
            mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0020, 4'h8, 1'h1, 5'h01,
                4'h0}));
        join
        mac.pulse(1'h1, 1'h0);
        mac.pulse(1'h0, 1'h1);
        exp_cnt[IDX_LATE] += 32'h2;
        exp_cnt[IDX_SQE] += 32'h2;
        exp_cnt[IDX_OCT_IN] += 32'h20;
        exp_cnt[IDX_UNI_IN] += 32'h1;
        exp_cnt[IDX_OCT_OUT] += 32'h20;
        exp_cnt[IDX_UNI_OUT] += 32'h1;
        exp_cnt[IDX_COLL_ONE] += 32'h1;
        check_bank("pulse");
    endtask : t_pulse

    // clear against same-cycle events, then counting resumes
    task automatic t_clear;
        fork
            mac.pulse(1'h1, 1'h1);
            mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0040, 9'h1FF}));
            mac.send_tx(esc_tx_evt_t'({1'h1, 16'h0040, 4'h9, 1'h1, 5'h02,
                4'hF}));
            begin
                @(negedge clk);
                clear <= 1'h1;
                @(negedge clk);
                clear <= 1'h0;
            end
        join
        for (int i = 0; i < NUM_CNT; i++) exp_cnt[i] = CNT_RST;
        check_bank("clear");
        mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0008, 9'h080}));
        exp_cnt[IDX_OCT_IN] = 32'h8;
        exp_cnt[IDX_GRP_IN] = 32'h1;
        check_bank("after_clear");
        // clear, then a unicast frame in the very next cycle
        fork
            begin
                @(negedge clk);
                clear <= 1'h1;
                @(negedge clk);
                clear <= 1'h0;
            end
            begin
                @(negedge clk);
                mac.send_rx(esc_rx_evt_t'({1'h1, 16'h0010, 9'h100}));
            end
        join
        // let the edge after the frame pass for the checks behind it
        @(negedge clk);
        for (int i = 0; i < NUM_CNT; i++) exp_cnt[i] = CNT_RST;
        exp_cnt[IDX_OCT_IN] = 32'h10;
        exp_cnt[IDX_UNI_IN] = 32'h1;
        check_bank("clear_uni");
    endtask : t_clear

    // ==========================================
    // main sequence: reset for five cycles, then scenarios
    initial begin
        err_count = 0;
        check_count = 0;
        rst = 1'h1;
        clear = 1'h0;
        for (int i = 0; i < NUM_CNT; i++) exp_cnt[i] = CNT_RST;
        repeat (5) @(negedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check_bank("reset");
        t_rx();
        t_tx();
        t_pulse();
        t_clear();
        conclude();
    end

    // watchdog: the scenarios need well under a microsecond
    initial begin
        #20000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : testbench
